// ---- verilog/jog_anti_jam_pkg.sv ----
package jog_anti_jam_pkg;

  // ==========================================================
  // timing
  localparam int unsigned SYS_CLK_MHZ      = 250;
  localparam int unsigned PHASE_TICK_US    = 1000;
  localparam int unsigned PHASE_TICK_CYCLES = PHASE_TICK_US * SYS_CLK_MHZ;

  // ==========================================================
  // jog torque level, percent
  localparam logic [6:0] TORQUE_RESET      = 7'h14;
  localparam logic [6:0] TORQUE_MIN        = 7'h0a;
  localparam logic [6:0] TORQUE_MAX        = 7'h64;
  localparam logic [6:0] EMB_TORQUE_MAX    = 7'h32;
  // current limit in hundredths of nominal: 20% -> 100, 100% -> 300
  localparam logic [8:0] CURRENT_OFFSET    = 9'h032;

  // fieldbus drive state that allows a trigger
  localparam logic [3:0] STATE_OP_ENABLED  = 4'h5;

  // ==========================================================
  // configuration encodings
  localparam logic [1:0] SRC_NONE          = 2'h0;
  localparam logic [1:0] SRC_DIGITAL       = 2'h1;
  localparam logic [1:0] SRC_CONTROL_WORD  = 2'h2;

  localparam logic [1:0] JOG_DISABLED      = 2'h0;
  localparam logic [1:0] JOG_BY_TERMINAL   = 2'h1;
  localparam logic [1:0] JOG_BY_LINE       = 2'h2;

  localparam logic [1:0] WIRE_HARDWIRED    = 2'h0;
  localparam logic [1:0] WIRE_TWO          = 2'h1;
  localparam logic [1:0] WIRE_THREE        = 2'h2;

  localparam logic [1:0] RV_VERY_LOW_FORCE = 2'h0;
  localparam logic [1:0] RV_LOW_FORCE      = 2'h1;
  localparam logic [1:0] RV_STARTER        = 2'h2;

  typedef enum logic [2:0] {
    SPD_NONE,
    SPD_FULL,
    SPD_SLOW,
    SPD_VERY_SLOW,
    SPD_LOW_FORCE,
    SPD_VERY_LOW_FORCE
  } speed_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_REVERSE,
    PH_STOP_A,
    PH_FORWARD,
    PH_STOP_B
  } aj_phase_t;

endpackage

// ---- verilog/anti_jam_seq_if.sv ----
`timescale 1ns/1ns
interface anti_jam_seq_if;
  import jog_anti_jam_pkg::*;
  logic        start;
  logic        abort;
  logic        tick;
  logic [15:0] rev_time;
  logic [15:0] fwd_time;
  logic [15:0] stop_time;
  logic [7:0]  cycles;
  aj_phase_t   phase;
  logic        done;

  modport ctrl (output start, abort, tick, rev_time, fwd_time, stop_time, cycles,
                input phase, done);
  modport seq  (input start, abort, tick, rev_time, fwd_time, stop_time, cycles,
                output phase, done);
endinterface

// ---- verilog/anti_jam_cycler.sv ----
`timescale 1ns/1ns
module anti_jam_cycler
  import jog_anti_jam_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   rst,
  anti_jam_seq_if.seq sq
);

  aj_phase_t   phase_reg, phase_next;
  logic [15:0] time_reg, time_next;
  logic [7:0]  cyc_reg, cyc_next;
  logic        done_reg, done_next;

  assign sq.phase = phase_reg;
  assign sq.done  = done_reg;

  // ==========================================================
  // reverse, stop, forward, stop; repeated per cycle count
  always_comb begin
    phase_next = phase_reg;
    time_next  = time_reg;
    cyc_next   = cyc_reg;
    done_next  = 1'b0;
    if (sq.abort) begin
      phase_next = PH_IDLE;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (sq.start) begin
            phase_next = PH_REVERSE;
            time_next  = sq.rev_time;
            cyc_next   = sq.cycles;
          end
        end
        default: begin
          if (sq.tick) begin
            if (time_reg > 16'h0001) begin
              time_next = time_reg - 16'h0001;
            end else begin
              case (phase_reg)
                PH_REVERSE: begin
                  phase_next = PH_STOP_A;
                  time_next  = sq.stop_time;
                end
                PH_STOP_A: begin
                  phase_next = PH_FORWARD;
                  time_next  = sq.fwd_time;
                end
                PH_FORWARD: begin
                  phase_next = PH_STOP_B;
                  time_next  = sq.stop_time;
                end
                default: begin
                  if (cyc_reg > 8'h01) begin
                    cyc_next   = cyc_reg - 8'h01;
                    phase_next = PH_REVERSE;
                    time_next  = sq.rev_time;
                  end else begin
                    phase_next = PH_IDLE;
                    done_next  = 1'b1;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase_reg <= PH_IDLE;
      time_reg  <= 16'h0000;
      cyc_reg   <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      time_reg  <= time_next;
      cyc_reg   <= cyc_next;
      done_reg  <= done_next;
    end
  end

endmodule

// ---- verilog/jog_and_anti_jam_sequencer.sv ----
`timescale 1ns/1ns
module jog_and_anti_jam_sequencer
  import jog_anti_jam_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = PHASE_TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        digital_input_trigger,
  input  wire logic        control_word_bit_source,
  input  wire logic [1:0]  trigger_select,
  input  wire logic        halt_bit,
  input  wire logic        standard_profile,
  input  wire logic [3:0]  drive_state,
  input  wire logic        auto_trigger_enable,
  input  wire logic        current_overload,
  input  wire logic        run_order,
  input  wire logic        motor_standstill,
  input  wire logic [1:0]  wire_control,
  input  wire logic        two_wire_transition,
  input  wire logic        anti_jam_external,
  input  wire logic [1:0]  reverse_speed_select,
  input  wire logic [15:0] reverse_time_ms,
  input  wire logic [15:0] forward_time_ms,
  input  wire logic [15:0] stop_time_ms,
  input  wire logic [7:0]  cycle_count,
  input  wire logic [1:0]  jog_assign,
  input  wire logic        jog_request,
  input  wire logic        jog_reverse_cmd,
  input  wire logic        jog_speed_select_source,
  input  wire logic        jog_speed_input,
  input  wire logic        jog_reverse_method,
  input  wire logic        torque_write,
  input  wire logic [6:0]  torque_write_data,
  output logic             motor_run,
  output logic             motor_reverse,
  output speed_t           motor_speed,
  output logic             internal_phase_reversal,
  output logic             reverse_contactor,
  output logic [6:0]       torque_limit,
  output logic [8:0]       current_limit,
  output logic [6:0]       jog_torque_level,
  output logic             jog_active,
  output logic             anti_jam_active,
  output logic             force_terminal_channel
);

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_JOG, ST_AJ_HALTING, ST_AJ_SEQ} mode_t;

  anti_jam_seq_if sq ();

  anti_jam_cycler u_cycler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sq      (sq)
  );

  // ==========================================================
  // pin synchroniser and edge memory
  logic        di_meta_reg, di_sync_reg, trig_prev_reg, ovl_prev_reg;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic        tick_reg, tick_next;

  mode_t       mode_reg, mode_next;
  logic        manual_reg, manual_next;
  logic        need_new_run_reg, need_new_run_next;
  logic [6:0]  torque_reg, torque_next;

  logic        run_next, rev_next, inv_next, cont_next, jog_next, aj_next, term_next;
  speed_t      speed_next;
  logic [6:0]  tlim_next;
  logic [8:0]  ilim_next;

  logic        manual_level, trig_allowed, manual_rise, auto_rise, trig_release;
  logic        transition_start;

  always_comb begin
    case (trigger_select)
      SRC_DIGITAL:      manual_level = di_sync_reg;
      SRC_CONTROL_WORD: manual_level = control_word_bit_source;
      default:          manual_level = 1'b0;
    endcase
    trig_allowed = !halt_bit && (!standard_profile || drive_state == STATE_OP_ENABLED);
    manual_rise  = manual_level && !trig_prev_reg && trig_allowed;
    auto_rise    = auto_trigger_enable && current_overload && !ovl_prev_reg;
    trig_release = manual_reg && !manual_level;
    // transition-style control needs a fresh run order after a digital trigger
    transition_start = (trigger_select == SRC_DIGITAL) &&
                       (wire_control == WIRE_THREE ||
                        (wire_control == WIRE_TWO && two_wire_transition));
  end

  // ==========================================================
  // phase tick divider; a long count so it is a parameter
  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
    if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_next = 32'h0000_0000;
      tick_next     = 1'b1;
    end
  end

  assign sq.tick      = tick_reg;
  assign sq.rev_time  = reverse_time_ms;
  assign sq.fwd_time  = forward_time_ms;
  assign sq.stop_time = stop_time_ms;
  assign sq.cycles    = cycle_count;

  // ==========================================================
  // mode control
  always_comb begin
    mode_next         = mode_reg;
    manual_next       = manual_reg;
    need_new_run_next = need_new_run_reg && run_order;
    torque_next       = torque_reg;
    sq.start          = 1'b0;
    sq.abort          = 1'b0;
    if (torque_write) begin
      if (torque_write_data < TORQUE_MIN) begin
        torque_next = TORQUE_MIN;
      end else if (torque_write_data > TORQUE_MAX) begin
        torque_next = TORQUE_MAX;
      end else begin
        torque_next = torque_write_data;
      end
    end
    case (mode_reg)
      ST_IDLE, ST_RUN, ST_JOG: begin
        // triggers only considered while idle or running, not during jog or a sequence
        if ((manual_rise || auto_rise) && mode_reg != ST_JOG) begin
          mode_next   = ST_AJ_HALTING;
          manual_next = manual_rise && !auto_rise;
          if (manual_rise && !auto_rise && transition_start) begin
            need_new_run_next = 1'b1;
          end
        end else if (mode_reg == ST_JOG) begin
          if ((!jog_request || jog_assign == JOG_DISABLED) && motor_standstill) begin
            mode_next = ST_IDLE;
          end
        end else if (jog_request && jog_assign != JOG_DISABLED && motor_standstill) begin
          mode_next = ST_JOG;
        end else if (mode_reg == ST_IDLE && run_order && !need_new_run_reg) begin
          mode_next = ST_RUN;
        end else if (mode_reg == ST_RUN && !run_order) begin
          mode_next = ST_IDLE;
        end
      end
      ST_AJ_HALTING: begin
        if (halt_bit || trig_release) begin
          mode_next = ST_IDLE;
        end else if (motor_standstill) begin
          sq.start  = 1'b1;
          mode_next = ST_AJ_SEQ;
        end
      end
      ST_AJ_SEQ: begin
        if (halt_bit || trig_release) begin
          sq.abort  = 1'b1;
          mode_next = ST_IDLE;
        end else if (sq.done) begin
          mode_next = (run_order && !need_new_run_reg) ? ST_RUN : ST_IDLE;
        end
      end
      default: mode_next = ST_IDLE;
    endcase
    if (mode_next == ST_IDLE || mode_next == ST_RUN) begin
      manual_next = 1'b0;
    end
  end

  // ==========================================================
  // motor command
  always_comb begin
    run_next   = 1'b0;
    rev_next   = 1'b0;
    speed_next = SPD_NONE;
    tlim_next  = torque_reg;
    jog_next   = 1'b0;
    aj_next    = 1'b0;
    term_next  = (jog_assign == JOG_BY_TERMINAL);
    case (mode_next)
      ST_RUN: begin
        run_next   = 1'b1;
        speed_next = SPD_FULL;
        tlim_next  = TORQUE_MAX;
      end
      ST_JOG: begin
        jog_next   = 1'b1;
        // drop power first; jog is left only once the rotor has stopped
        run_next   = jog_request && jog_assign != JOG_DISABLED;
        rev_next   = run_next && jog_reverse_cmd;
        speed_next = (jog_speed_select_source && jog_speed_input) ? SPD_VERY_SLOW : SPD_SLOW;
      end
      ST_AJ_HALTING: begin
        aj_next = 1'b1;
      end
      ST_AJ_SEQ: begin
        aj_next   = 1'b1;
        tlim_next = anti_jam_external ? TORQUE_MAX :
                    (torque_reg > EMB_TORQUE_MAX ? EMB_TORQUE_MAX : torque_reg);
        if (sq.phase == PH_REVERSE || (mode_reg == ST_AJ_HALTING)) begin
          run_next = 1'b1;
          rev_next = 1'b1;
          if (reverse_speed_select == RV_STARTER && anti_jam_external) begin
            speed_next = SPD_FULL;
          end else if (reverse_speed_select == RV_VERY_LOW_FORCE) begin
            speed_next = SPD_VERY_LOW_FORCE;
          end else begin
            speed_next = SPD_LOW_FORCE;
          end
        end else if (sq.phase == PH_FORWARD) begin
          run_next   = 1'b1;
          speed_next = SPD_FULL;
        end
      end
      default: ;
    endcase
    // which method reverses depends on function
    if (mode_next == ST_JOG) begin
      inv_next  = rev_next && !jog_reverse_method;
      cont_next = rev_next && jog_reverse_method;
    end else begin
      inv_next  = rev_next && !anti_jam_external;
      cont_next = rev_next && anti_jam_external;
    end
    // 2.5 x percent + 50, in hundredths of nominal current
    ilim_next = 9'((({2'b00, tlim_next} * 9'h005) >> 1) + CURRENT_OFFSET);
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      di_meta_reg             <= 1'b0;
      di_sync_reg             <= 1'b0;
      trig_prev_reg           <= 1'b0;
      ovl_prev_reg            <= 1'b0;
      tick_cnt_reg            <= 32'h0000_0000;
      tick_reg                <= 1'b0;
      mode_reg                <= ST_IDLE;
      manual_reg              <= 1'b0;
      need_new_run_reg        <= 1'b0;
      torque_reg              <= TORQUE_RESET;
      motor_run               <= 1'b0;
      motor_reverse           <= 1'b0;
      motor_speed             <= SPD_NONE;
      internal_phase_reversal <= 1'b0;
      reverse_contactor       <= 1'b0;
      torque_limit            <= TORQUE_RESET;
      current_limit           <= 9'h064;
      jog_torque_level        <= TORQUE_RESET;
      jog_active              <= 1'b0;
      anti_jam_active         <= 1'b0;
      force_terminal_channel  <= 1'b0;
    end else begin
      di_meta_reg             <= digital_input_trigger;
      di_sync_reg             <= di_meta_reg;
      trig_prev_reg           <= manual_level;
      ovl_prev_reg            <= current_overload;
      tick_cnt_reg            <= tick_cnt_next;
      tick_reg                <= tick_next;
      mode_reg                <= mode_next;
      manual_reg              <= manual_next;
      need_new_run_reg        <= need_new_run_next;
      torque_reg              <= torque_next;
      motor_run               <= run_next;
      motor_reverse           <= rev_next;
      motor_speed             <= speed_next;
      internal_phase_reversal <= inv_next;
      reverse_contactor       <= cont_next;
      torque_limit            <= tlim_next;
      current_limit           <= ilim_next;
      jog_torque_level        <= torque_next;
      jog_active              <= jog_next;
      anti_jam_active         <= aj_next;
      force_terminal_channel  <= term_next;
    end
  end

endmodule

// ---- verification/jog_anti_jam_props.sv ----
`timescale 1ns/1ns
module jog_anti_jam_checker
  import jog_anti_jam_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       control_word_bit_source,
  input wire logic [1:0] trigger_select,
  input wire logic       halt_bit,
  input wire logic       standard_profile,
  input wire logic [3:0] drive_state,
  input wire logic       auto_trigger_enable,
  input wire logic       current_overload,
  input wire logic       motor_standstill,
  input wire logic       anti_jam_external,
  input wire logic       jog_speed_select_source,
  input wire logic       jog_speed_input,
  input wire logic       motor_run,
  input wire logic       motor_reverse,
  input wire speed_t     motor_speed,
  input wire logic       internal_phase_reversal,
  input wire logic       reverse_contactor,
  input wire logic [6:0] torque_limit,
  input wire logic [8:0] current_limit,
  input wire logic [6:0] jog_torque_level,
  input wire logic       jog_active,
  input wire logic       anti_jam_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // reset and torque mapping
  reset_values_a: assert property (disable iff (1'b0) rst |=>
    jog_torque_level == TORQUE_RESET && current_limit == 9'h064 && !motor_run && !anti_jam_active)
    else $error("reset values wrong");
  // current limit is registered on the same edge as the torque limit; still wait for two quiet edges
  current_map_a: assert property ($stable(torque_limit) ##1 $stable(torque_limit) |->
    current_limit == 9'(torque_limit) * 9'h005 / 9'h002 + CURRENT_OFFSET)
    else $error("current limit off");

  // ==========================================================
  // trigger acceptance
  cw_trigger_a: assert property (trigger_select == SRC_CONTROL_WORD &&
    $rose(control_word_bit_source) && !halt_bit && !anti_jam_active && !jog_active &&
    (!standard_profile || drive_state == STATE_OP_ENABLED) |=> anti_jam_active && !motor_run)
    else $error("trigger not taken");
  op_state_a: assert property (trigger_select == SRC_CONTROL_WORD && standard_profile &&
    $rose(control_word_bit_source) && drive_state != STATE_OP_ENABLED &&
    !anti_jam_active && !auto_trigger_enable |=> !anti_jam_active)
    else $error("trigger outside state 5");
  halt_wins_a: assert property (halt_bit |=> !anti_jam_active)
    else $error("halt not honoured");
  release_abort_a: assert property (anti_jam_active && trigger_select == SRC_CONTROL_WORD &&
    !auto_trigger_enable && $fell(control_word_bit_source) |=> !anti_jam_active)
    else $error("release did not abort");
  auto_trig_a: assert property (auto_trigger_enable && $rose(current_overload) &&
    !halt_bit && !anti_jam_active && !jog_active |=> anti_jam_active && !motor_run)
    else $error("overload did not trigger");

  // ==========================================================
  // reverse phase limits per mode
  embedded_rev_a: assert property (anti_jam_active && motor_run && motor_reverse &&
    !anti_jam_external && $stable(anti_jam_external) |->
    motor_speed inside {SPD_LOW_FORCE, SPD_VERY_LOW_FORCE} && torque_limit <= EMB_TORQUE_MAX)
    else $error("embedded reverse too strong");
  external_rev_a: assert property (anti_jam_active && motor_run && anti_jam_external &&
    $stable(anti_jam_external) |-> torque_limit == TORQUE_MAX &&
    (!motor_reverse || (reverse_contactor && !internal_phase_reversal)))
    else $error("external mode output wrong");

  // ==========================================================
  // jog
  jog_speed_a: assert property (jog_active && motor_run &&
    $stable({jog_speed_select_source, jog_speed_input}) |->
    motor_speed == ((jog_speed_select_source && jog_speed_input) ? SPD_VERY_SLOW : SPD_SLOW))
    else $error("jog speed wrong");
  jog_standstill_a: assert property ($changed(jog_active) |-> $past(motor_standstill))
    else $error("jog changed while turning");

  cover property (anti_jam_active && motor_run && motor_reverse);
  cover property ($fell(anti_jam_active) && motor_run);
  cover property (jog_active && motor_run && motor_speed == SPD_VERY_SLOW);
endmodule

bind jog_and_anti_jam_sequencer jog_anti_jam_checker CHK (
  .sys_clk, .rst, .control_word_bit_source, .trigger_select, .halt_bit, .standard_profile,
  .drive_state, .auto_trigger_enable, .current_overload, .motor_standstill,
  .anti_jam_external, .jog_speed_select_source, .jog_speed_input, .motor_run,
  .motor_reverse, .motor_speed, .internal_phase_reversal, .reverse_contactor,
  .torque_limit, .current_limit, .jog_torque_level, .jog_active, .anti_jam_active
);

// ---- verification/motor_stage_model.sv ----
`timescale 1ns/1ns
module motor_stage_model #(
  parameter int SPIN_DOWN = 6
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic motor_run,
  output logic      motor_standstill
);
  // ==========================================================
  // rotor coasts for a while after power is removed
  int coast_reg;
  always_ff @(posedge sys_clk) begin
    if (rst || motor_run) begin
      coast_reg <= SPIN_DOWN;
    end else if (coast_reg != 0) begin
      coast_reg <= coast_reg - 1;
    end
  end
  assign motor_standstill = (coast_reg == 0);
endmodule

// ---- verification/jog_and_anti_jam_sequencer_test.sv ----
`timescale 1ns/1ns
module jog_and_anti_jam_sequencer_test;
  import jog_anti_jam_pkg::*;
  logic        sys_clk, rst, digital_input_trigger, control_word_bit_source, halt_bit;
  logic        standard_profile, auto_trigger_enable, current_overload, run_order;
  logic        motor_standstill, two_wire_transition, anti_jam_external, jog_request;
  logic        jog_reverse_cmd, jog_speed_select_source, jog_speed_input;
  logic        jog_reverse_method, torque_write;
  logic [1:0]  trigger_select, wire_control, reverse_speed_select, jog_assign;
  logic [3:0]  drive_state;
  logic [15:0] reverse_time_ms, forward_time_ms, stop_time_ms;
  logic [7:0]  cycle_count;
  logic [6:0]  torque_write_data, torque_limit, jog_torque_level;
  logic [8:0]  current_limit;
  logic        motor_run, motor_reverse, internal_phase_reversal, reverse_contactor;
  logic        jog_active, anti_jam_active, force_terminal_channel;
  speed_t      motor_speed;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [6:0]  wr [4] = '{7'h7f, 7'h05, 7'h64, 7'h50};
  logic [6:0]  ex [4] = '{7'h64, 7'h0a, 7'h64, 7'h50};

  jog_and_anti_jam_sequencer #(.TICK_CYCLES(4)) DUT (
    .sys_clk, .rst, .digital_input_trigger, .control_word_bit_source, .trigger_select,
    .halt_bit, .standard_profile, .drive_state, .auto_trigger_enable, .current_overload,
    .run_order, .motor_standstill, .wire_control, .two_wire_transition, .anti_jam_external,
    .reverse_speed_select, .reverse_time_ms, .forward_time_ms, .stop_time_ms, .cycle_count,
    .jog_assign, .jog_request, .jog_reverse_cmd, .jog_speed_select_source, .jog_speed_input,
    .jog_reverse_method, .torque_write, .torque_write_data, .motor_run, .motor_reverse,
    .motor_speed, .internal_phase_reversal, .reverse_contactor, .torque_limit,
    .current_limit, .jog_torque_level, .jog_active, .anti_jam_active, .force_terminal_channel
  );
  motor_stage_model MOTOR (.sys_clk, .rst, .motor_run, .motor_standstill);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // helpers
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic pick(int w);
    case (w)
      0: return anti_jam_active;
      1: return jog_active;
      2: return motor_run;
      default: return motor_run & motor_reverse;
    endcase
  endfunction
  task automatic wait_for(int w, logic v);
    int n;
    n = 0;
    #1;
    while (pick(w) !== v && n < 600) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 600) begin
      mismatches++;
      $display("ERROR wait %0d expected %b seen timeout", w, v);
      close_out();
    end
  endtask
  // one full sequence, trigger already raised by the caller
  task automatic aj_seq(logic [2:0] spd, logic [6:0] tq, logic ext, logic run_after);
    wait_for(0, 1'b1);
    check("halted", motor_run, 1'b0);
    wait_for(3, 1'b1);
    check("rev speed", motor_speed, spd);
    check("aj torque", torque_limit, tq);
    check("contactor", reverse_contactor, ext);
    check("int rev", internal_phase_reversal, !ext);
    wait_for(2, 1'b0);
    wait_for(2, 1'b1);
    check("fwd dir", motor_reverse, 1'b0);
    check("fwd speed", motor_speed, SPD_FULL);
    wait_for(0, 1'b0);
    cyc(2);
    #1;
    check("run after", motor_run, run_after);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {digital_input_trigger, control_word_bit_source, halt_bit, standard_profile,
     auto_trigger_enable, current_overload, run_order, two_wire_transition,
     anti_jam_external, jog_request, jog_reverse_cmd, jog_speed_select_source,
     jog_speed_input, jog_reverse_method, torque_write, trigger_select, wire_control,
     reverse_speed_select, jog_assign, drive_state, torque_write_data} = '0;
    rst = 1'b1;
    {reverse_time_ms, forward_time_ms, stop_time_ms} = {3{16'h0002}};
    cycle_count = 8'h01;
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    #1;
    check("torque rst", jog_torque_level, TORQUE_RESET);
    check("current rst", current_limit, 9'h064);
    foreach (wr[i]) begin
      cyc(1);
      torque_write <= 1'b1;
      torque_write_data <= wr[i];
      cyc(1);
      torque_write <= 1'b0;
      cyc(1);
      #1;
      check("torque", jog_torque_level, ex[i]);
    end
    $display("test torque done");

    cyc(1);
    jog_assign <= JOG_BY_TERMINAL;
    cyc(3);
    #1;
    check("terminal", force_terminal_channel, 1'b1);
    cyc(1);
    jog_assign <= JOG_BY_LINE;
    jog_request <= 1'b1;
    wait_for(2, 1'b1);
    check("jog", jog_active, 1'b1);
    check("slow", motor_speed, SPD_SLOW);
    check("line", force_terminal_channel, 1'b0);
    for (int m = 0; m < 2; m++) begin
      cyc(1);
      {jog_speed_select_source, jog_speed_input, jog_reverse_cmd} <= 3'h7;
      jog_reverse_method <= m[0];
      cyc(3);
      #1;
      check("very slow", motor_speed, SPD_VERY_SLOW);
      check("jog int rev", internal_phase_reversal, !m[0]);
      check("jog contactor", reverse_contactor, m[0]);
    end
    cyc(1);
    {jog_request, jog_reverse_cmd, jog_reverse_method} <= 3'h0;
    wait_for(1, 1'b0);
    check("jog left", motor_standstill, 1'b1);
    $display("test jog done");

    for (int e = 0; e < 2; e++) begin
      cyc(1);
      anti_jam_external <= e[0];
      reverse_speed_select <= e[0] ? RV_STARTER : RV_LOW_FORCE;
      cycle_count <= 8'(e + 1);
      trigger_select <= SRC_CONTROL_WORD;
      standard_profile <= 1'b1;
      drive_state <= STATE_OP_ENABLED;
      run_order <= 1'b1;
      wait_for(2, 1'b1);
      cyc(1);
      control_word_bit_source <= 1'b1;
      aj_seq(e[0] ? SPD_FULL : SPD_LOW_FORCE, e[0] ? TORQUE_MAX : EMB_TORQUE_MAX, e[0], 1'b1);
      cyc(1);
      control_word_bit_source <= 1'b0;
    end
    $display("test modes done");

    cyc(1);
    drive_state <= 4'h4;
    control_word_bit_source <= 1'b1;
    cyc(3);
    #1;
    check("not op", anti_jam_active, 1'b0);
    cyc(1);
    control_word_bit_source <= 1'b0;
    drive_state <= STATE_OP_ENABLED;
    halt_bit <= 1'b1;
    cyc(1);
    control_word_bit_source <= 1'b1;
    cyc(3);
    #1;
    check("halt block", anti_jam_active, 1'b0);
    for (int a = 0; a < 2; a++) begin
      cyc(1);
      {control_word_bit_source, halt_bit} <= 2'h0;
      cyc(1);
      control_word_bit_source <= 1'b1;
      wait_for(0, 1'b1);
      cyc(1);
      if (a == 0) control_word_bit_source <= 1'b0;
      else halt_bit <= 1'b1;
      cyc(2);
      #1;
      check("abort", anti_jam_active, 1'b0);
    end
    cyc(1);
    {control_word_bit_source, halt_bit} <= 2'h0;
    $display("test refusals done");

    cyc(1);
    trigger_select <= SRC_NONE;
    auto_trigger_enable <= 1'b1;
    wait_for(2, 1'b1);
    cyc(1);
    current_overload <= 1'b1;
    aj_seq(SPD_FULL, TORQUE_MAX, 1'b1, 1'b1);
    cyc(1);
    {current_overload, auto_trigger_enable} <= 2'h0;
    $display("test overload done");

    for (int w = 0; w < 2; w++) begin
      cyc(1);
      trigger_select <= SRC_DIGITAL;
      standard_profile <= 1'b0;
      wire_control <= w[0] ? WIRE_TWO : WIRE_THREE;
      two_wire_transition <= 1'b1;
      wait_for(2, 1'b1);
      cyc(1);
      digital_input_trigger <= 1'b1;
      aj_seq(SPD_FULL, TORQUE_MAX, 1'b1, 1'b0);
      cyc(1);
      {digital_input_trigger, run_order} <= 2'h0;
      cyc(2);
      run_order <= 1'b1;
      wait_for(2, 1'b1);
      check("new run", motor_run, 1'b1);
    end
    $display("test wire control done");
    close_out();
  end
endmodule
